// file: shared/sfl_pkg.sv
// constants for the forwarding and learning control bank
// assumes one clock, registers on a plain address/strobe port
package sfl_pkg;
   localparam int          NPORT        = 9;
   localparam int          IMP_BIT      = 8;
   localparam logic [7:0]  OFS_MISS_MAP = 8'h34;
   localparam logic [7:0]  OFS_IP_MULTICAST_MAP = 8'h36;
   localparam logic [7:0]  OFS_RXP_MAP  = 8'h38;
   localparam logic [7:0]  OFS_TXP_MAP  = 8'h3a;
   localparam logic [7:0]  OFS_LRN_OFF  = 8'h3c;
   localparam logic [7:0]  OFS_SW_LRN   = 8'h3e;
   localparam logic [7:0]  OFS_FWD_CTL  = 8'h21;
   localparam int          FWD_EN_BIT   = 6;
   localparam logic [8:0]  MAP_RST      = 9'h000;
   localparam logic [7:0]  FWD_CTL_RST  = 8'h00;
endpackage

// file: rtl/sfl_port_policy.sv
// per-port pause and learning decisions
// assumes maps come from registers on the same clock
module sfl_port_policy #(
   parameter int NPORT = 9
) (
   input  wire logic [NPORT-1:0] rxp_map_i,
   input  wire logic [NPORT-1:0] txp_map_i,
   input  wire logic [NPORT-1:0] lrn_off_i,
   input  wire logic [NPORT-1:0] sw_lrn_i,
   input  wire logic [NPORT-1:0] rx_pause_i,
   input  wire logic [NPORT-1:0] tx_pause_i,
   input  wire logic [NPORT-1:0] sa_unknown_i,
   input  wire logic [NPORT-1:0] sa_known_i,
   input  wire logic [NPORT-1:0] sw_learn_ok_i,
   output logic      [NPORT-1:0] rx_pause_act_o,
   output logic      [NPORT-1:0] tx_pause_act_o,
   output logic      [NPORT-1:0] learn_o,
   output logic      [NPORT-1:0] refresh_o,
   output logic      [NPORT-1:0] copy_cpu_o
);
   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_port
         // software learning: hw learning off, software decides
         assign learn_o[g] = sa_unknown_i[g] & ~lrn_off_i[g]
            & (sw_lrn_i[g] ? sw_learn_ok_i[g] : 1'b1);
         // refresh keeps running in software learning mode
         assign refresh_o[g]  = sa_known_i[g] & ~lrn_off_i[g];
         assign copy_cpu_o[g] = sa_unknown_i[g] & sw_lrn_i[g];
         assign tx_pause_act_o[g] = tx_pause_i[g] & ~txp_map_i[g];
         assign rx_pause_act_o[g] = rx_pause_i[g] & ~rxp_map_i[g];
      end
   endgenerate
endmodule // sfl_port_policy

// file: rtl/sfl_ctrl.sv
// forwarding / learning control register bank and decisions
// assumes single clock, lookup events from same-clock logic
//----------------------------------------
// How it works
//----------------------------------------
// How it works
// - miss with enable: send to map ports
// - all-zero selected map (miss map, or ip map for ip misses) drops frame
// - set bit forwards, clear bit excludes
// - rx pause ignored where bit set
// - tx pause map covers nine ports
// - learning-off bit stops source learning
// - soft learning copies unknown source out
// - soft learning: software decides learning
// - refresh still works in soft learning
// - soft learning clear means hardware operation
//
// Decided for this implementation: strobed register access.
module sfl_ctrl #(
   parameter int NPORT = sfl_pkg::NPORT
) (
   input  wire logic             mclk_i,
   input  wire logic             rstn_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [15:0]      wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [15:0]      rdata_o,
   input  wire logic             miss_i,
   input  wire logic             miss_ip_i,
   output logic                  fwd_valid_o,
   output logic      [NPORT-1:0] fwd_map_o,
   output logic                  fwd_drop_o,
   input  wire logic [NPORT-1:0] rx_pause_i,
   input  wire logic [NPORT-1:0] tx_pause_i,
   input  wire logic [NPORT-1:0] sa_unknown_i,
   input  wire logic [NPORT-1:0] sa_known_i,
   input  wire logic [NPORT-1:0] sw_learn_ok_i,
   output logic      [NPORT-1:0] rx_pause_act_o,
   output logic      [NPORT-1:0] tx_pause_act_o,
   output logic      [NPORT-1:0] learn_o,
   output logic      [NPORT-1:0] refresh_o,
   output logic      [NPORT-1:0] copy_cpu_o
);
   //----------------------------------------
   // registers
   //----------------------------------------
   logic [NPORT-1:0] miss_map, ip_multicast_map, txp_map, lrn_off, sw_lrn;
   logic [7:0]       rxp_map;
   logic [7:0]       fwd_ctl;
   logic             mcast_miss_forward_enable;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   wire w_miss = wr_i & hit(addr_i, sfl_pkg::OFS_MISS_MAP);
   wire w_ip_multicast = wr_i & hit(addr_i, sfl_pkg::OFS_IP_MULTICAST_MAP);
   wire w_rxp  = wr_i & hit(addr_i, sfl_pkg::OFS_RXP_MAP);
   wire w_txp  = wr_i & hit(addr_i, sfl_pkg::OFS_TXP_MAP);
   wire w_lrn  = wr_i & hit(addr_i, sfl_pkg::OFS_LRN_OFF);
   wire w_sw   = wr_i & hit(addr_i, sfl_pkg::OFS_SW_LRN);
   wire w_fctl = wr_i & hit(addr_i, sfl_pkg::OFS_FWD_CTL);

   assign mcast_miss_forward_enable = fwd_ctl[sfl_pkg::FWD_EN_BIT];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         miss_map <= sfl_pkg::MAP_RST;
         ip_multicast_map <= sfl_pkg::MAP_RST;
         rxp_map  <= sfl_pkg::MAP_RST[7:0];
         txp_map  <= sfl_pkg::MAP_RST;
         lrn_off  <= sfl_pkg::MAP_RST;
         sw_lrn   <= sfl_pkg::MAP_RST;
         fwd_ctl  <= sfl_pkg::FWD_CTL_RST;
      end else begin
         // only bits 8:0 stored (7:0 for rxp_map and fwd_ctl); upper bits are read-only zero
         if (w_miss) miss_map <= wdata_i[8:0];
         if (w_ip_multicast) ip_multicast_map <= wdata_i[8:0];
         if (w_rxp)  rxp_map  <= wdata_i[7:0];
         if (w_txp)  txp_map  <= wdata_i[8:0];
         if (w_lrn)  lrn_off  <= wdata_i[8:0];
         if (w_sw)   sw_lrn   <= wdata_i[8:0];
         if (w_fctl) fwd_ctl  <= wdata_i[7:0];
      end
   end

   //----------------------------------------
   // read path: unmapped addresses read zero
   //----------------------------------------
   logic [15:0] next_rdata;
   always_comb begin
      case (addr_i)
         sfl_pkg::OFS_MISS_MAP: next_rdata = {7'h00, miss_map};
         sfl_pkg::OFS_IP_MULTICAST_MAP: next_rdata = {7'h00, ip_multicast_map};
         sfl_pkg::OFS_RXP_MAP:  next_rdata = {8'h00, rxp_map};
         sfl_pkg::OFS_TXP_MAP:  next_rdata = {7'h00, txp_map};
         sfl_pkg::OFS_LRN_OFF:  next_rdata = {7'h00, lrn_off};
         sfl_pkg::OFS_SW_LRN:   next_rdata = {7'h00, sw_lrn};
         sfl_pkg::OFS_FWD_CTL:  next_rdata = {8'h00, fwd_ctl};
         default:               next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) rdata_o <= 16'h0000;
      else if (rd_i) rdata_o <= next_rdata;
      else rdata_o <= 16'h0000;
   end

   //----------------------------------------
   // multicast lookup failure forwarding
   //----------------------------------------
   // ip multicast misses take the ip map instead of the miss map
   wire [NPORT-1:0] sel_map = miss_ip_i ? ip_multicast_map : miss_map;
   wire [NPORT-1:0] next_map = mcast_miss_forward_enable
                               ? sel_map : '0;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fwd_valid_o <= 1'b0;
         fwd_map_o   <= '0;
         fwd_drop_o  <= 1'b0;
      end else begin
         fwd_valid_o <= miss_i;
         fwd_map_o   <= miss_i ? next_map : '0;
         fwd_drop_o  <= miss_i & (next_map == '0);
      end
   end

   //----------------------------------------
   // per-port policy, registered out
   //----------------------------------------
   logic [NPORT-1:0] rxa, txa, lrn, rfr, cpy;
   sfl_port_policy #(.NPORT(NPORT)) u_pol (
      .rxp_map_i      ({1'b0, rxp_map}), // management port has no rx bit
      .txp_map_i      (txp_map),
      .lrn_off_i      (lrn_off),
      .sw_lrn_i       (sw_lrn),
      .rx_pause_i     (rx_pause_i),
      .tx_pause_i     (tx_pause_i),
      .sa_unknown_i   (sa_unknown_i),
      .sa_known_i     (sa_known_i),
      .sw_learn_ok_i  (sw_learn_ok_i),
      .rx_pause_act_o (rxa),
      .tx_pause_act_o (txa),
      .learn_o        (lrn),
      .refresh_o      (rfr),
      .copy_cpu_o     (cpy)
   );

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_pause_act_o <= '0;
         tx_pause_act_o <= '0;
         learn_o        <= '0;
         refresh_o      <= '0;
         copy_cpu_o     <= '0;
      end else begin
         rx_pause_act_o <= rxa;
         tx_pause_act_o <= txa;
         learn_o        <= lrn;
         refresh_o      <= rfr;
         copy_cpu_o     <= cpy;
      end
   end

   //----------------------------------------
   // assertions
   //----------------------------------------
   property p_miss_fwd;
      @(posedge mclk_i) disable iff (!rstn_i)
      miss_i && mcast_miss_forward_enable && !miss_ip_i
         |=> fwd_map_o == $past(miss_map);
   endproperty
   a_miss_fwd: assert property (p_miss_fwd)
      else $error("miss map not forwarded");

   property p_drop;
      @(posedge mclk_i) disable iff (!rstn_i)
      fwd_valid_o |-> fwd_drop_o == (fwd_map_o == '0);
   endproperty
   a_drop: assert property (p_drop)
      else $error("drop flag wrong");

   property p_ip_multicast;
      @(posedge mclk_i) disable iff (!rstn_i)
      miss_i && mcast_miss_forward_enable && miss_ip_i
         |=> fwd_map_o == $past(ip_multicast_map);
   endproperty
   a_ip_multicast: assert property (p_ip_multicast)
      else $error("ip map not used");

   property p_upper_zero;
      @(posedge mclk_i) disable iff (!rstn_i)
      rd_i && addr_i != sfl_pkg::OFS_FWD_CTL |=> rdata_o[15:9] == 7'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("reserved bits not zero");

   property p_rxp;
      @(posedge mclk_i) disable iff (!rstn_i)
      rx_pause_i[0] && rxp_map[0] |=> !rx_pause_act_o[0];
   endproperty
   a_rxp: assert property (p_rxp)
      else $error("rx pause not ignored");

   property p_txp;
      @(posedge mclk_i) disable iff (!rstn_i)
      tx_pause_i[8] && !txp_map[8] |=> tx_pause_act_o[8];
   endproperty
   a_txp: assert property (p_txp)
      else $error("tx pause not honoured");

   property p_lrn_off;
      @(posedge mclk_i) disable iff (!rstn_i)
      lrn_off[1] |=> !learn_o[1];
   endproperty
   a_lrn_off: assert property (p_lrn_off)
      else $error("learning not disabled");

   property p_copy;
      @(posedge mclk_i) disable iff (!rstn_i)
      sa_unknown_i[2] && sw_lrn[2] |=> copy_cpu_o[2];
   endproperty
   a_copy: assert property (p_copy)
      else $error("unknown source not copied");

   property p_refresh;
      @(posedge mclk_i) disable iff (!rstn_i)
      sa_known_i[3] && sw_lrn[3] && !lrn_off[3] |=> refresh_o[3];
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh lost in soft learning");

   property p_hw_learn;
      @(posedge mclk_i) disable iff (!rstn_i)
      sa_unknown_i[4] && !sw_lrn[4] && !lrn_off[4] |=> learn_o[4];
   endproperty
   a_hw_learn: assert property (p_hw_learn)
      else $error("hardware learning missing");

   property p_off_drop;
      @(posedge mclk_i) disable iff (!rstn_i)
      miss_i && !mcast_miss_forward_enable
         |=> fwd_drop_o && fwd_map_o == '0;
   endproperty
   a_off_drop: assert property (p_off_drop)
      else $error("miss with enable clear not dropped");

   property p_imp_fwd;
      @(posedge mclk_i) disable iff (!rstn_i)
      miss_i && mcast_miss_forward_enable && !miss_ip_i
         && miss_map[sfl_pkg::IMP_BIT] |=> fwd_map_o[sfl_pkg::IMP_BIT];
   endproperty
   a_imp_fwd: assert property (p_imp_fwd)
      else $error("management port not forwarded");

   property p_excl;
      @(posedge mclk_i) disable iff (!rstn_i)
      miss_i && mcast_miss_forward_enable && !miss_ip_i && !miss_map[1]
         |=> !fwd_map_o[1];
   endproperty
   a_excl: assert property (p_excl)
      else $error("excluded port forwarded");

   property p_fwd_pulse;
      @(posedge mclk_i) disable iff (!rstn_i)
      !miss_i |=> !fwd_valid_o && !fwd_drop_o;
   endproperty
   a_fwd_pulse: assert property (p_fwd_pulse)
      else $error("forward result without miss");

   // first edge after any reset release: maps must come up cleared
   property p_rst_ip_multicast;
      @(posedge mclk_i)
      rstn_i && !$past(rstn_i) |-> ip_multicast_map == '0 && miss_map == '0;
   endproperty
   a_rst_ip_multicast: assert property (p_rst_ip_multicast)
      else $error("forward maps not cleared by reset");

   property p_rst_pause;
      @(posedge mclk_i)
      rstn_i && !$past(rstn_i) |-> rxp_map == '0 && txp_map == '0;
   endproperty
   a_rst_pause: assert property (p_rst_pause)
      else $error("pause maps not cleared by reset");

   property p_rst_lrn;
      @(posedge mclk_i)
      rstn_i && !$past(rstn_i) |-> lrn_off == '0 && sw_lrn == '0;
   endproperty
   a_rst_lrn: assert property (p_rst_lrn)
      else $error("learning maps not cleared by reset");

   property p_rx_honour;
      @(posedge mclk_i) disable iff (!rstn_i)
      rx_pause_i[1] && !rxp_map[1] |=> rx_pause_act_o[1];
   endproperty
   a_rx_honour: assert property (p_rx_honour)
      else $error("rx pause not honoured");

   property p_imp_rx;
      @(posedge mclk_i) disable iff (!rstn_i)
      rx_pause_i[sfl_pkg::IMP_BIT] |=> rx_pause_act_o[sfl_pkg::IMP_BIT];
   endproperty
   a_imp_rx: assert property (p_imp_rx)
      else $error("management rx pause not honoured");

   property p_rxp_upper;
      @(posedge mclk_i) disable iff (!rstn_i)
      rd_i && addr_i == sfl_pkg::OFS_RXP_MAP |=> rdata_o[15:8] == 8'h00;
   endproperty
   a_rxp_upper: assert property (p_rxp_upper)
      else $error("rx pause upper bits not zero");

   property p_tx_ignore;
      @(posedge mclk_i) disable iff (!rstn_i)
      tx_pause_i[0] && txp_map[0] |=> !tx_pause_act_o[0];
   endproperty
   a_tx_ignore: assert property (p_tx_ignore)
      else $error("tx pause not ignored");

   property p_lrn_off_rfr;
      @(posedge mclk_i) disable iff (!rstn_i)
      lrn_off[0] |=> !refresh_o[0];
   endproperty
   a_lrn_off_rfr: assert property (p_lrn_off_rfr)
      else $error("refresh with learning off");

   property p_soft_gate;
      @(posedge mclk_i) disable iff (!rstn_i)
      sa_unknown_i[5] && sw_lrn[5] && !sw_learn_ok_i[5] |=> !learn_o[5];
   endproperty
   a_soft_gate: assert property (p_soft_gate)
      else $error("hardware learned in soft mode");

   property p_soft_ok;
      @(posedge mclk_i) disable iff (!rstn_i)
      sa_unknown_i[4] && sw_lrn[4] && sw_learn_ok_i[4] && !lrn_off[4]
         |=> learn_o[4];
   endproperty
   a_soft_ok: assert property (p_soft_ok)
      else $error("software learning request lost");

   property p_no_copy;
      @(posedge mclk_i) disable iff (!rstn_i)
      !sw_lrn[0] |=> !copy_cpu_o[0];
   endproperty
   a_no_copy: assert property (p_no_copy)
      else $error("copy without soft learning");

   c_miss_fwd: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      fwd_valid_o && !fwd_drop_o);
   c_miss_drop: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      fwd_valid_o && fwd_drop_o);
   c_copy: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      |copy_cpu_o);
   c_ip_miss: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      miss_i && miss_ip_i && mcast_miss_forward_enable);
   c_soft_learn: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      |(learn_o & sw_lrn));
endmodule // sfl_ctrl

// file: verification/tb_sfl_ctrl.sv
// bench for the forwarding and learning control bank
// assumes sfl_pkg compiled first, one 50 MHz clock, no partner model
module tb_sfl_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic [7:0]  a;
      logic [15:0] d;
      logic [15:0] e;
   } sfl_row_t;
   logic                       mclk_i = 1'b0;
   logic                       rstn_i = 1'b0;
   logic [7:0]                 addr_i = 8'h00;
   logic [15:0]                wdata_i = 16'h0000;
   logic                       wr_i = 1'b0;
   logic                       rd_i = 1'b0;
   logic                       miss_i = 1'b0;
   logic                       miss_ip_i = 1'b0;
   logic [sfl_pkg::NPORT-1:0]  rxp_i = '0, txp_i = '0, unk_i = '0;
   logic [sfl_pkg::NPORT-1:0]  kn_i = '0, ok_i = '0;
   logic [15:0]                rdata_o;
   logic                       fwd_valid_o, fwd_drop_o;
   logic [sfl_pkg::NPORT-1:0]  fwd_map_o, rxa_o, txa_o, lrn_o, rfr_o, cpy_o;
   int                         mismatches = 0;
   int                         compares = 0;
   sfl_row_t rows [10] = '{
      '{8'h34, 16'hffff, 16'h01ff}, '{8'h36, 16'hffff, 16'h01ff},
      '{8'h38, 16'hffff, 16'h00ff}, '{8'h3a, 16'hffff, 16'h01ff},
      '{8'h3c, 16'hffff, 16'h01ff}, '{8'h3e, 16'hffff, 16'h01ff},
      '{8'h21, 16'hffbf, 16'h00bf}, '{8'h40, 16'hffff, 16'h0000},
      '{8'h34, 16'h0105, 16'h0105}, '{8'h36, 16'h00a2, 16'h00a2}};

   always #10 mclk_i = ~mclk_i;

   sfl_ctrl u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .miss_i(miss_i), .miss_ip_i(miss_ip_i), .fwd_valid_o(fwd_valid_o),
      .fwd_map_o(fwd_map_o), .fwd_drop_o(fwd_drop_o), .rx_pause_i(rxp_i),
      .tx_pause_i(txp_i), .sa_unknown_i(unk_i), .sa_known_i(kn_i),
      .sw_learn_ok_i(ok_i), .rx_pause_act_o(rxa_o), .tx_pause_act_o(txa_o),
      .learn_o(lrn_o), .refresh_o(rfr_o), .copy_cpu_o(cpy_o));

   //----------------------------------------
   // shared tasks
   //----------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1 chk("rdata", rdata_o, e);
   endtask

   // one miss pulse, result looked at in the single cycle it stands
   task automatic miss(input logic ip, input logic [8:0] m, input logic dr);
      @(posedge mclk_i);
      miss_i    <= 1'b1;
      miss_ip_i <= ip;
      @(posedge mclk_i);
      miss_i    <= 1'b0;
      #1 chk("fwd_valid", 16'(fwd_valid_o), 16'h0001);
      chk("fwd_map", 16'(fwd_map_o), 16'(m));
      chk("fwd_drop", 16'(fwd_drop_o), 16'(dr));
      @(posedge mclk_i);
      #1 chk("fwd_valid", 16'(fwd_valid_o), 16'h0000);
      chk("fwd_drop", 16'(fwd_drop_o), 16'h0000);
   endtask

   task automatic report_and_stop;
      if (mismatches == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #(20 * 3000);
      mismatches++;
      report_and_stop;
   end

   //----------------------------------------
   // main sequence
   //----------------------------------------
   initial begin
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      miss(1'b0, 9'h000, 1'b1);
      wr(8'h21, 16'h0040);
      miss(1'b0, 9'h105, 1'b0);
      miss(1'b1, 9'h0a2, 1'b0);
      wr(8'h34, 16'h0000);
      miss(1'b0, 9'h000, 1'b1);
      // pause: rx map has no management bit, so bit 8 always honours
      wr(8'h38, 16'h01a5);
      wr(8'h3a, 16'h0103);
      wr(8'h3c, 16'h0003);
      wr(8'h3e, 16'h0032);
      @(posedge mclk_i);
      rxp_i <= 9'h1ff;
      txp_i <= 9'h1ff;
      unk_i <= 9'h1fd;
      kn_i  <= 9'h1ff;
      ok_i  <= 9'h010;
      @(posedge mclk_i);
      #1 chk("rx_pause_act", 16'(rxa_o), 16'h015a);
      chk("tx_pause_act", 16'(txa_o), 16'h00fc);
      chk("learn", 16'(lrn_o), 16'h01dc);
      chk("refresh", 16'(rfr_o), 16'h01fc);
      chk("copy_cpu", 16'(cpy_o), 16'h0030);
      @(posedge mclk_i);
      unk_i <= 9'h000;
      @(posedge mclk_i);
      #1 chk("copy_cpu", 16'(cpy_o), 16'h0000);
      chk("learn", 16'(lrn_o), 16'h0000);
      // second reset in mid-run with pause still applied
      @(posedge mclk_i);
      rstn_i <= 1'b0;
      @(posedge mclk_i);
      #1 chk("rx_pause_act", 16'(rxa_o), 16'h0000);
      chk("refresh", 16'(rfr_o), 16'h0000);
      @(posedge mclk_i);
      rstn_i <= 1'b1;
      #1 chk("tx_pause_act", 16'(txa_o), 16'h0000);
      rd(8'h34, 16'h0000);
      rd(8'h36, 16'h0000);
      rd(8'h38, 16'h0000);
      rd(8'h3a, 16'h0000);
      rd(8'h3c, 16'h0000);
      rd(8'h3e, 16'h0000);
      rd(8'h21, 16'h0000);
      @(posedge mclk_i);
      #1 chk("learn", 16'(lrn_o), 16'h0000);
      report_and_stop;
   end
endmodule // tb_sfl_ctrl
